// ---- dv/lcrc_bench.sv ----
/*
  Self-checking bench of lcrc_top with short counts.
  Assumes lcrc_machine as contactors and the bound checker.
*/
`timescale 1ns/1ns
`default_nettype none
module lcrc_bench;
  import lcrc_pkg::*;
  localparam int unsigned MIN = 5;
  localparam int unsigned MAX = 40;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] beam_clear = 16'hffff;
  logic [1:0] signal_strength = 2'h0;
  logic restart_contact = 1'b1;
  logic select_bridged = 1'b1;
  logic feedback_select_bridged = 1'b0;
  logic welded = 1'b0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, fbk, sa, sb, irq, start_interlock, restart_disabled, ready_to_unlock;
  lcrc_level_t align_level;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed = 32'h19afc91c;
  int i;
  lcrc_top #(.ALIGN_OPEN_CYC(20), .PRESS_MIN_CYC(MIN), .PRESS_MAX_CYC(MAX)) lcrc_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .beam_clear(beam_clear),
    .signal_strength(signal_strength), .restart_contact(restart_contact),
    .select_bridged(select_bridged), .feedback_select_bridged(feedback_select_bridged),
    .contactor_feedback_monitor(fbk), .safety_output_a(sa), .safety_output_b(sb),
    .align_level(align_level), .start_interlock(start_interlock),
    .restart_disabled(restart_disabled), .ready_to_unlock(ready_to_unlock), .irq(irq));
  lcrc_machine lcrc_machine_i (.clk(hclk), .drive_a(sa), .drive_b(sb), .welded(welded),
    .feedback(fbk));
  ////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  function automatic lcrc_level_t lvl(input logic [1:0] ss);
    return (ss == 2'h0) ? LCRC_LVL_WEAK : (ss == 2'h1) ? LCRC_LVL_MEDIUM : LCRC_LVL_MAX;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= a;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rst(input logic sel, input logic rc, input logic fsb);
    hresetn <= 1'b0;
    select_bridged <= sel;
    restart_contact <= rc;
    feedback_select_bridged <= fsb;
    cyc(20);
    hresetn <= 1'b1;
  endtask
  task automatic press(input int n);
    restart_contact <= 1'b0;
    cyc(n);
    restart_contact <= 1'b1;
    cyc(4);
  endtask
  task automatic wait_on(input logic v);
    for (int k = 0; k < 60 && sa !== v; k++) cyc(1);
    chk(sa, v);
  endtask
  // block one random beam, let contactors drop
  task automatic trip();
    beam_clear <= ~(16'h1 << ($random(seed) & 15));
    wait_on(1'b0);
    cyc(4);
  endtask
  ////////////////////
  initial begin
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    rst(1'b0, 1'b0, 1'b0);
    cyc(8);
    bus(1'b0, 8'h04, 32'h0);
    chk(rd[4:0], 5'h01);
    cyc(20);
    bus(1'b0, 8'h04, 32'h0);
    chk({rd[15], rd[4:0]}, 6'h22);
    for (i = 0; i < 4; i++) begin
      signal_strength <= i[1:0];
      cyc(3);
      chk(align_level, lvl(i[1:0]));
      chk(sa, 1'b0);
    end
    beam_clear <= 16'hfffe;
    cyc(3);
    chk(align_level, LCRC_LVL_NO_SYNC);
    beam_clear <= ~(16'h2 << ($random(seed) & 7));
    cyc(3);
    chk(align_level, LCRC_LVL_BLOCKED);
    beam_clear <= 16'hffff;
    rst(1'b1, 1'b1, 1'b0);
    wait_on(1'b1);
    bus(1'b0, 8'h04, 32'h0);
    chk(rd[13:12], 2'h1);
    trip();
    chk(irq, 1'b0);
    chk(restart_disabled, 1'b1);
    bus(1'b1, 8'h0c, 32'h1f);
    cyc(1);
    chk(irq, 1'b1);
    bus(1'b0, 8'h08, 32'h0);
    chk(rd & 32'h9, 32'h9);
    repeat (3) begin
      beam_clear <= 16'hffff;
      wait_on(1'b1);
      trip();
    end
    beam_clear <= 16'hffff;
    wait_on(1'b1);
    bus(1'b1, 8'h08, 32'h1f);
    bus(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    cyc(1);
    chk(irq, 1'b0);
    bus(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    // run enable cleared forces outputs off, set again restores them
    bus(1'b1, 8'h00, 32'h0);
    wait_on(1'b0);
    bus(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, 8'h00, 32'h1);
    wait_on(1'b1);
    rst(1'b0, 1'b1, 1'b0);
    wait_on(1'b1);
    trip();
    chk(start_interlock, 1'b1);
    chk(restart_disabled, 1'b1);
    chk(ready_to_unlock, 1'b0);
    press(10);
    chk(start_interlock, 1'b1);
    beam_clear <= 16'hffff;
    cyc(3);
    chk(ready_to_unlock, 1'b1);
    bus(1'b0, 8'h04, 32'h0);
    chk({rd[16], rd[14], rd[4:0]}, 7'h70);
    press(MIN - 1);
    press(MAX + 1);
    chk(start_interlock, 1'b1);
    bus(1'b0, 8'h08, 32'h0);
    chk(rd & 32'h4, 32'h4);
    press(MIN);
    wait_on(1'b1);
    trip();
    beam_clear <= 16'hffff;
    press(MAX);
    wait_on(1'b1);
    welded <= 1'b1;
    trip();
    beam_clear <= 16'hffff;
    press(10);
    cyc(10);
    chk(sa, 1'b0);
    bus(1'b0, 8'h08, 32'h0);
    chk(rd & 32'h10, 32'h10);
    rst(1'b1, 1'b1, 1'b1);
    wait_on(1'b1);
    bus(1'b0, 8'h04, 32'h0);
    chk(rd[14], 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire

// ---- dv/lcrc_machine.sv ----
/*
  Contactor pair with a feedback contact.
  Assumes the safety outputs as coil drive.
*/
`timescale 1ns/1ns
`default_nettype none
module lcrc_machine (
  // clock
  input wire logic clk,
  // coil drive and weld fault
  input wire logic drive_a,
  input wire logic drive_b,
  input wire logic welded,
  // feedback, 1 = released
  output logic feedback
);
  logic [1:0] pull_q = 2'h0;
  // contactors pull in two cycles after drive
  always @(posedge clk) begin
    pull_q <= {pull_q[0], drive_a & drive_b};
  end
  assign feedback = ~pull_q[1] & ~welded;
endmodule
`default_nettype wire

// ---- dv/lcrc_top_properties.sv ----
/*
  Port checker of lcrc_top, bound into it.
  Assumes one clock, hclk, and reset hresetn.
*/
`timescale 1ns/1ns
`default_nettype none
module lcrc_top_properties #(
  parameter int unsigned N_BEAMS = 16,
  parameter int unsigned ALIGN_OPEN_CYC = 20,
  parameter int unsigned PRESS_MIN_CYC = 5,
  parameter int unsigned PRESS_MAX_CYC = 40
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // field and button
  input wire logic [N_BEAMS-1:0] beam_clear,
  input wire logic restart_contact,
  // outputs and indication
  input wire logic safety_output_a,
  input wire logic safety_output_b,
  input wire lcrc_pkg::lcrc_level_t align_level,
  input wire logic start_interlock,
  input wire logic restart_disabled,
  input wire logic ready_to_unlock
);
  import lcrc_pkg::*;
  logic [31:0] low_q, low_d, len_q, len_d;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  ////////////////////
  // length of the last press
  always_comb begin
    low_d = restart_contact ? 32'h0 : low_q + 32'h1;
    len_d = (restart_contact && low_q != 32'h0) ? low_q : len_q;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_q <= 32'h0;
      len_q <= 32'h0;
    end else begin
      low_q <= low_d;
      len_q <= len_d;
    end
  end
  ////////////////////
  chk_outputs_pair: assert property (safety_output_a == safety_output_b)
    else $error("safety outputs differ");
  chk_trip_opens: assert property (!(&beam_clear) |-> ##[1:2] !safety_output_a)
    else $error("blocked beam left outputs on");
  chk_rise_clear: assert property ($rose(safety_output_a) |-> $past(&beam_clear))
    else $error("outputs rose with a beam blocked");
  chk_align_off: assert property (align_level != LCRC_LVL_NO_SYNC |-> !safety_output_a)
    else $error("outputs on in alignment");
  chk_level_clear: assert property (align_level >= LCRC_LVL_WEAK |-> $past(&beam_clear))
    else $error("signal level shown with a beam blocked");
  chk_interlock_off: assert property (start_interlock |-> !safety_output_a && restart_disabled)
    else $error("interlock with outputs on");
  chk_ready_lock: assert property (ready_to_unlock |-> start_interlock)
    else $error("ready shown outside interlock");
  chk_hold_pressed: assert property (start_interlock && !restart_contact |=> start_interlock)
    else $error("interlock left while button held");
  chk_press_window: assert property ($fell(start_interlock) |->
    len_q >= PRESS_MIN_CYC && len_q <= PRESS_MAX_CYC)
    else $error("interlock left without a valid press");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  cover property ($fell(safety_output_a));
  cover property ($fell(start_interlock));
  cover property (align_level == LCRC_LVL_MAX);
endmodule
bind lcrc_top lcrc_top_properties #(.N_BEAMS(N_BEAMS), .ALIGN_OPEN_CYC(ALIGN_OPEN_CYC),
  .PRESS_MIN_CYC(PRESS_MIN_CYC), .PRESS_MAX_CYC(PRESS_MAX_CYC)) lcrc_top_properties_i (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .beam_clear(beam_clear), .restart_contact(restart_contact),
  .safety_output_a(safety_output_a), .safety_output_b(safety_output_b),
  .align_level(align_level), .start_interlock(start_interlock),
  .restart_disabled(restart_disabled), .ready_to_unlock(ready_to_unlock));
`default_nettype wire

// ---- verilog/lcrc_cfg.svh ----
/*
  Constants of the light curtain restart controller: register offsets,
  field positions, reset values and timing counts.
  Assumes a 125 MHz hclk; included by bare name where needed.
*/
// Overview of operation
// - in alignment mode both safety outputs stay off, whatever the alignment quality.
// - at power-up the unit enters alignment when the restart contact stays open for 1 s.
// - the alignment indicator shows five levels: no sync, sync with a beam blocked, weak, medium, max.
// - the beam nearest the cable end, beam 0, is the synchronization beam.
// - any interrupted beam opens both safety outputs and puts the unit in its safe state.
// - in automatic reset the outputs close again as soon as every beam is clear.
// - in manual reset the outputs stay open in an indicated interlock until clear beams and a restart.
// - after the reset mode is detected the unit starts in alignment and moves on after the first good alignment.
// - a press and release of the reset button lasting 0.5 s to 4 s releases the interlock and turns outputs on.
// - while locked out the indicator shows restart disabled, and in manual mode also field clear and ready.
// - feedback monitoring is off when the select input is bridged to output a, on when fed through a closed contact.
// - a bridged select line means automatic reset, a closed restart contact manual, both open alignment only.
`ifndef LCRC_CFG_SVH
`define LCRC_CFG_SVH

`define LCRC_CLK_HZ 125000000
`define LCRC_CYC_PER_MS (`LCRC_CLK_HZ / 1000)
`define LCRC_ALIGN_OPEN_MS 1000
`define LCRC_PRESS_MIN_MS 500
`define LCRC_PRESS_MAX_MS 4000
`define LCRC_ALIGN_OPEN_CYC (`LCRC_ALIGN_OPEN_MS * `LCRC_CYC_PER_MS)
`define LCRC_PRESS_MIN_CYC (`LCRC_PRESS_MIN_MS * `LCRC_CYC_PER_MS)
`define LCRC_PRESS_MAX_CYC (`LCRC_PRESS_MAX_MS * `LCRC_CYC_PER_MS)

`define LCRC_OFS_CTRL 8'h00
`define LCRC_OFS_STATUS 8'h04
`define LCRC_OFS_IRQ_STAT 8'h08
`define LCRC_OFS_IRQ_MASK 8'h0c

`define LCRC_CTRL_RUN_EN 0
`define LCRC_CTRL_RST 32'h0000_0001

`define LCRC_ST_STATE_LSB 0
`define LCRC_ST_LEVEL_LSB 8
`define LCRC_ST_MODE_LSB 12
`define LCRC_ST_FBK_ACT 14
`define LCRC_ST_ALIGN_LOCK 15
`define LCRC_ST_READY 16

`define LCRC_EV_TRIP 0
`define LCRC_EV_UNLOCK 1
`define LCRC_EV_BAD_PRESS 2
`define LCRC_EV_ALIGNED 3
`define LCRC_EV_FBK_HOLD 4
`define LCRC_EV_N 5

`endif

// ---- verilog/lcrc_pkg.sv ----
/*
  Types of the light curtain restart controller.
  Assumes nothing of its surroundings.
*/
package lcrc_pkg;

  typedef enum logic [4:0] {
    LCRC_PWRUP = 5'b00001,
    LCRC_ALIGN = 5'b00010,
    LCRC_RUN = 5'b00100,
    LCRC_SAFE = 5'b01000,
    LCRC_LOCK = 5'b10000
  } lcrc_state_t;

  typedef enum logic [1:0] {
    LCRC_MODE_ALIGN = 2'h0,
    LCRC_MODE_AUTO = 2'h1,
    LCRC_MODE_MANUAL = 2'h2
  } lcrc_mode_t;

  typedef enum logic [2:0] {
    LCRC_LVL_NO_SYNC = 3'h0,
    LCRC_LVL_BLOCKED = 3'h1,
    LCRC_LVL_WEAK = 3'h2,
    LCRC_LVL_MEDIUM = 3'h3,
    LCRC_LVL_MAX = 3'h4
  } lcrc_level_t;

endpackage

// ---- verilog/lcrc_press_timer.sv ----
/*
  Reset button press timer: measures one press and grades it on release.
  Assumes the pressed level is synchronous to clk.
*/
`timescale 1ns/1ns
`default_nettype none
module lcrc_press_timer #(
  parameter int unsigned W = 29,
  parameter logic [28:0] MIN_CYC = 29'd62500000,
  parameter logic [28:0] MAX_CYC = 29'd500000000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // button
  input wire logic pressed,
  // grading, one-cycle pulses on release
  output logic press_ok,
  output logic press_bad
);

  logic [W-1:0] cnt_q, cnt_d;
  logic pressed_q, pressed_d;
  logic release_w;
  logic in_window;

  assign release_w = pressed_q & ~pressed;
  assign in_window = (cnt_q >= MIN_CYC) && (cnt_q <= MAX_CYC);

  always_comb begin
    pressed_d = pressed;
    cnt_d = cnt_q;
    if (!pressed) begin
      cnt_d = '0;
    end else if (cnt_q <= MAX_CYC) begin
      // saturates one above the longest press
      cnt_d = cnt_q + W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      pressed_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      pressed_q <= pressed_d;
    end
  end

  assign press_ok = release_w & in_window;
  assign press_bad = release_w & ~in_window;

endmodule
`default_nettype wire

// ---- verilog/lcrc_top.sv ----
/*
  Light curtain restart controller: alignment grading, trip, automatic or
  manual restart with a timed button press, contactor feedback check, and
  an AHB-Lite register slave with a level interrupt.
  Assumes all inputs synchronous to hclk and a single AHB-Lite master.
*/
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "lcrc_cfg.svh"
module lcrc_top #(
  parameter int unsigned N_BEAMS = 16,
  parameter int unsigned ALIGN_OPEN_CYC = `LCRC_ALIGN_OPEN_CYC,
  parameter int unsigned PRESS_MIN_CYC = `LCRC_PRESS_MIN_CYC,
  parameter int unsigned PRESS_MAX_CYC = `LCRC_PRESS_MAX_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // optics: 1 = beam received, beam 0 nearest the cable end
  input wire logic [N_BEAMS-1:0] beam_clear,
  input wire logic [1:0] signal_strength,
  // wiring and operator
  input wire logic restart_contact,
  input wire logic select_bridged,
  input wire logic feedback_select_bridged,
  input wire logic contactor_feedback_monitor,
  // safety outputs
  output logic safety_output_a,
  output logic safety_output_b,
  // indication
  output lcrc_pkg::lcrc_level_t align_level,
  output logic start_interlock,
  output logic restart_disabled,
  output logic ready_to_unlock,
  // interrupt
  output logic irq
);
  import lcrc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // optics and wiring decode

  logic sync_found;
  logic all_clear;
  logic align_good;
  logic fbk_active;
  logic fbk_ok;
  lcrc_level_t level_w;
  lcrc_mode_t mode_w;

  assign sync_found = beam_clear[0];
  assign all_clear = &beam_clear;

  always_comb begin
    if (!sync_found) begin
      level_w = LCRC_LVL_NO_SYNC;
    end else if (!all_clear) begin
      level_w = LCRC_LVL_BLOCKED;
    end else if (signal_strength == 2'h0) begin
      level_w = LCRC_LVL_WEAK;
    end else if (signal_strength == 2'h1) begin
      level_w = LCRC_LVL_MEDIUM;
    end else begin
      level_w = LCRC_LVL_MAX;
    end
  end

  assign align_good = sync_found & all_clear;

  always_comb begin
    if (select_bridged) begin
      mode_w = LCRC_MODE_AUTO;
    end else if (restart_contact) begin
      mode_w = LCRC_MODE_MANUAL;
    end else begin
      mode_w = LCRC_MODE_ALIGN;
    end
  end

  assign fbk_active = ~feedback_select_bridged;
  // closed feedback contact shows the contactors released
  assign fbk_ok = ~fbk_active | contactor_feedback_monitor;

  ////////////////////////////////////////////////////////////////////////
  // reset button press grading

  logic press_ok;
  logic press_bad;
  logic btn_pressed;

  // the normally closed button opens the restart contact
  assign btn_pressed = ~restart_contact;

  lcrc_press_timer #(
    .W(29),
    .MIN_CYC(29'(PRESS_MIN_CYC)),
    .MAX_CYC(29'(PRESS_MAX_CYC))
  ) lcrc_press_timer_i (
    .clk(hclk),
    .rst_n(hresetn),
    .pressed(btn_pressed),
    .press_ok(press_ok),
    .press_bad(press_bad)
  );

  ////////////////////////////////////////////////////////////////////////
  // register state

  logic [31:0] ctrl_q, ctrl_d;
  logic [`LCRC_EV_N-1:0] istat_q, istat_d;
  logic [`LCRC_EV_N-1:0] imask_q, imask_d;
  logic run_en;

  assign run_en = ctrl_q[`LCRC_CTRL_RUN_EN];

  ////////////////////////////////////////////////////////////////////////
  // operating sequence

  lcrc_state_t state_q, state_d;
  lcrc_mode_t mode_q, mode_d;
  logic align_lock_q, align_lock_d;
  logic [31:0] open_cnt_q, open_cnt_d;
  logic ev_trip;
  logic ev_unlock;
  logic ev_aligned;
  logic ev_fbk_hold;

  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    align_lock_d = align_lock_q;
    open_cnt_d = open_cnt_q;
    ev_trip = 1'b0;
    ev_unlock = 1'b0;
    ev_aligned = 1'b0;
    ev_fbk_hold = 1'b0;
    unique case (state_q)
      LCRC_PWRUP: begin
        if (mode_w != LCRC_MODE_ALIGN) begin
          // mode known: always through alignment first
          mode_d = mode_w;
          state_d = LCRC_ALIGN;
        end else if (open_cnt_q >= ALIGN_OPEN_CYC - 1) begin
          // contact held open long enough: alignment only
          mode_d = LCRC_MODE_ALIGN;
          align_lock_d = 1'b1;
          state_d = LCRC_ALIGN;
        end else begin
          open_cnt_d = open_cnt_q + 32'h1;
        end
      end
      LCRC_ALIGN: begin
        if (!align_lock_q && align_good) begin
          // first correct alignment hands over to the selected mode
          ev_aligned = 1'b1;
          if (fbk_ok) begin
            state_d = LCRC_RUN;
          end else begin
            ev_fbk_hold = 1'b1;
            state_d = (mode_q == LCRC_MODE_MANUAL) ? LCRC_LOCK : LCRC_SAFE;
          end
        end
      end
      LCRC_RUN: begin
        if (!all_clear) begin
          ev_trip = 1'b1;
          state_d = (mode_q == LCRC_MODE_MANUAL) ? LCRC_LOCK : LCRC_SAFE;
        end
      end
      LCRC_SAFE: begin
        if (all_clear) begin
          if (fbk_ok) begin
            state_d = LCRC_RUN;
          end else begin
            ev_fbk_hold = 1'b1;
          end
        end
      end
      LCRC_LOCK: begin
        // bad presses leave the interlock in place
        if (all_clear && press_ok) begin
          if (fbk_ok) begin
            ev_unlock = 1'b1;
            state_d = LCRC_RUN;
          end else begin
            ev_fbk_hold = 1'b1;
          end
        end
      end
      default: begin
        state_d = LCRC_SAFE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= LCRC_PWRUP;
      mode_q <= LCRC_MODE_ALIGN;
      align_lock_q <= 1'b0;
      open_cnt_q <= 32'h0;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      align_lock_q <= align_lock_d;
      open_cnt_q <= open_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs and indication

  logic out_on_q, out_on_d;
  lcrc_level_t level_q, level_d;
  logic lock_ind_q, lock_ind_d;
  logic dis_q, dis_d;
  logic ready_q, ready_d;

  always_comb begin
    // off in alignment, safe and interlock states
    out_on_d = (state_d == LCRC_RUN) && run_en && all_clear;
    level_d = (state_d == LCRC_ALIGN) ? level_w : LCRC_LVL_NO_SYNC;
    lock_ind_d = (state_d == LCRC_LOCK);
    dis_d = (state_d == LCRC_LOCK) || (state_d == LCRC_SAFE);
    ready_d = (state_d == LCRC_LOCK) && all_clear;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_on_q <= 1'b0;
      level_q <= LCRC_LVL_NO_SYNC;
      lock_ind_q <= 1'b0;
      dis_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      out_on_q <= out_on_d;
      level_q <= level_d;
      lock_ind_q <= lock_ind_d;
      dis_q <= dis_d;
      ready_q <= ready_d;
    end
  end

  assign safety_output_a = out_on_q;
  assign safety_output_b = out_on_q;
  assign align_level = level_q;
  assign start_interlock = lock_ind_q;
  assign restart_disabled = dis_q;
  assign ready_to_unlock = ready_q;

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states

  logic ap_valid;
  logic dp_wr_q, dp_wr_d;
  logic [7:0] dp_addr_q, dp_addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic [`LCRC_EV_N-1:0] events;
  logic [31:0] status_w;

  assign ap_valid = hsel & htrans[1] & hready;
  assign events = {ev_fbk_hold, ev_aligned, press_bad & (state_q == LCRC_LOCK),
                   ev_unlock, ev_trip};

  always_comb begin
    status_w = 32'h0;
    status_w[`LCRC_ST_STATE_LSB +: 5] = state_q;
    status_w[`LCRC_ST_LEVEL_LSB +: 3] = level_w;
    status_w[`LCRC_ST_MODE_LSB +: 2] = mode_q;
    status_w[`LCRC_ST_FBK_ACT] = fbk_active;
    status_w[`LCRC_ST_ALIGN_LOCK] = align_lock_q;
    status_w[`LCRC_ST_READY] = ready_q;
  end

  always_comb begin
    dp_wr_d = ap_valid & hwrite;
    dp_addr_d = ap_valid ? haddr : dp_addr_q;
    rdata_d = rdata_q;
    if (ap_valid && !hwrite) begin
      unique case (haddr)
        `LCRC_OFS_CTRL: rdata_d = ctrl_q;
        `LCRC_OFS_STATUS: rdata_d = status_w;
        `LCRC_OFS_IRQ_STAT: rdata_d = {27'h0, istat_q};
        `LCRC_OFS_IRQ_MASK: rdata_d = {27'h0, imask_q};
        default: rdata_d = 32'h0;
      endcase
    end
  end

  always_comb begin
    ctrl_d = ctrl_q;
    imask_d = imask_q;
    istat_d = istat_q;
    if (dp_wr_q) begin
      unique case (dp_addr_q)
        `LCRC_OFS_CTRL: ctrl_d = {31'h0, hwdata[`LCRC_CTRL_RUN_EN]};
        `LCRC_OFS_IRQ_MASK: imask_d = hwdata[`LCRC_EV_N-1:0];
        `LCRC_OFS_IRQ_STAT: istat_d = istat_q & ~hwdata[`LCRC_EV_N-1:0];
        default: ;
      endcase
    end
    // a new event wins over a clear in the same cycle
    istat_d = istat_d | events;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_q <= 1'b0;
      dp_addr_q <= 8'h00;
      rdata_q <= 32'h0;
      ctrl_q <= `LCRC_CTRL_RST;
      imask_q <= '0;
      istat_q <= '0;
    end else begin
      dp_wr_q <= dp_wr_d;
      dp_addr_q <= dp_addr_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      imask_q <= imask_d;
      istat_q <= istat_d;
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = |(istat_q & imask_q);

endmodule
`default_nettype wire
